// File: logic/codec_resp_pkg.sv
// package: command codes, response codes, result carrier types
// assumes one 40 MHz clock and synchronous active-low reset
package codec_resp_pkg;

   localparam int CMD_W  = 5;
   localparam int RESP_W = 5;
   localparam int ADDR_W = 24;
   localparam int LINE_W = 16;
   localparam int BIT_W  = 4;

   typedef enum logic [CMD_W-1:0] {
      platform_setup_command    = 5'h01,
      set_code_buffer           = 5'h02,
      set_image_buffer          = 5'h03,
      processing_setup_command  = 5'h04,
      statistics_setup_command  = 5'h05,
      continue_command          = 5'h06,
      abort_command             = 5'h07,
      statistics_read_command   = 5'h08,
      line_buffer_read_command  = 5'h09,
      block_operation_command   = 5'h0a,
      line_operation_command    = 5'h0b,
      read_line_tag             = 5'h0c,
      line_end_code             = 5'h0d,
      control_return_command    = 5'h0e,
      fill_command              = 5'h0f,
      white_mask_command        = 5'h10,
      transfer_operation_command = 5'h11,
      version_read_command      = 5'h12
   } cmd_t;

   typedef enum logic [RESP_W-1:0] {
      resp_none                 = 5'h00,
      block_encode_done         = 5'h01,
      block_decode_done         = 5'h02,
      block_decode_aborted      = 5'h03,
      code_buffer_empty         = 5'h04,
      code_buffer_full          = 5'h05,
      limit_state_command_error = 5'h06,
      line_buffer_report        = 5'h07,
      unknown_command_error     = 5'h08,
      duplicate_request_error   = 5'h09,
      line_end_added            = 5'h0a,
      line_end_found            = 5'h0b,
      fill_done                 = 5'h0c,
      line_encode_done          = 5'h0d,
      line_decode_done          = 5'h0e,
      line_decode_aborted       = 5'h0f,
      setup_done                = 5'h10,
      mask_done                 = 5'h11,
      continuous_stop_done      = 5'h12,
      statistics_report         = 5'h13,
      control_return_added      = 5'h14,
      control_return_found      = 5'h15,
      code_buffer_set_done      = 5'h16,
      image_buffer_set_done     = 5'h17,
      nothing_pending_done      = 5'h18,
      platform_setup_done       = 5'h19,
      tag_read_done             = 5'h1a,
      transfer_done             = 5'h1b,
      version_report            = 5'h1c
   } resp_t;

   // outcome reported by the processing engine
   typedef enum logic [2:0] {
      end_ok        = 3'h0,
      end_cb_empty  = 3'h1,
      end_cb_full   = 3'h2,
      end_err_lines = 3'h3,
      end_found     = 3'h4
   } outcome_t;

   // engine report: positions after the processed area
   typedef struct packed {
      outcome_t            outcome;
      logic                decode;
      logic [LINE_W-1:0]   lines;
      logic [ADDR_W-1:0]   image_addr;
      logic [ADDR_W-1:0]   code_addr;
      logic [BIT_W-1:0]    code_bit;
   } engine_rpt_t;

   // response word sent to the host
   typedef struct packed {
      resp_t               code;
      logic [LINE_W-1:0]   lines;
      logic [ADDR_W-1:0]   image_addr;
      logic [ADDR_W-1:0]   code_addr;
      logic [BIT_W-1:0]    code_bit;
   } response_t;

   localparam logic [LINE_W-1:0] LINES_ZERO = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ZERO  = 24'h000000;
   localparam logic [BIT_W-1:0]  BIT_ZERO   = 4'h0;
   localparam logic [ADDR_W-1:0] VERSION_WORD = 24'h000001; // arbitrary

endpackage

// File: logic/codec_response_generator.sv
// response generation and command acceptance of an image codec
// assumes the engine, statistics table and line buffer sit outside
module codec_response_generator
(
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   input  wire logic                         cmd_valid,
   input  wire logic [codec_resp_pkg::CMD_W-1:0] cmd_code,
   input  wire logic                         engine_done,
   input  wire codec_resp_pkg::engine_rpt_t  engine_rpt,
   input  wire logic                         completion_clear,
   output logic                              engine_start,
   output codec_resp_pkg::cmd_t              engine_cmd,
   output logic                              engine_single_line,
   output logic                              engine_cancel,
   output logic                              resp_valid,
   output codec_resp_pkg::response_t         resp,
   output logic                              interrupt,
   output logic                              completion_flag,
   output logic                              code_buffer_limit_state,
   output logic                              continuous_mode
);
   import codec_resp_pkg::*;

   typedef enum logic [1:0] {
      st_idle = 2'b00,
      st_busy = 2'b01
   } state_t;

   ////////////////////////////////////////////////////////////////////
   // command classification

   function automatic logic known_cmd(input logic [CMD_W-1:0] c);
      known_cmd = (c >= 5'h01) && (c <= 5'h12);
   endfunction

   function automatic logic limit_ok(input logic [CMD_W-1:0] c);
      case (c)
         5'h01, 5'h02, 5'h06, 5'h07, 5'h08, 5'h09: limit_ok = 1'b1;
         default:                                  limit_ok = 1'b0;
      endcase
   endfunction

   // commands answered at once, with no engine run
   function automatic logic immediate(input logic [CMD_W-1:0] c);
      case (c)
         5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h12:
            immediate = 1'b1;
         default:
            immediate = 1'b0;
      endcase
   endfunction

   function automatic response_t pack(input resp_t code,
                                      input engine_rpt_t r);
      pack.code       = code;
      pack.lines      = r.lines;
      pack.image_addr = r.image_addr;
      pack.code_addr  = r.code_addr;
      pack.code_bit   = r.code_bit;
   endfunction

   function automatic response_t plain(input resp_t code);
      plain.code       = code;
      plain.lines      = LINES_ZERO;
      plain.image_addr = ADDR_ZERO;
      plain.code_addr  = ADDR_ZERO;
      plain.code_bit   = BIT_ZERO;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // state

   state_t      state;
   cmd_t        last_op;   // repeated by continue
   logic        have_op;
   response_t   next_resp;
   logic        next_limit;
   logic        respond;
   logic        launch;
   cmd_t        launch_cmd;
   logic        launch_line;
   logic        end_cont;
   logic        set_cont;

   always_comb
   begin
      next_resp   = plain(resp_none);
      next_limit  = code_buffer_limit_state;
      respond     = 1'b0;
      launch      = 1'b0;
      launch_cmd  = last_op;
      launch_line = 1'b0;
      end_cont    = 1'b0;
      set_cont    = 1'b0;
      if (cmd_valid && state == st_busy)
      begin
         next_resp = plain(duplicate_request_error);
         respond   = 1'b1;
      end
      else if (cmd_valid)
      begin
         if (!known_cmd(cmd_code))
         begin
            next_resp = plain(unknown_command_error);
            respond   = 1'b1;
         end
         else if (code_buffer_limit_state && !limit_ok(cmd_code))
         begin
            next_resp = plain(limit_state_command_error);
            respond   = 1'b1;
         end
         else if (immediate(cmd_code))
         begin
            respond = 1'b1;
            case (cmd_t'(cmd_code))
               platform_setup_command:
                  next_resp = plain(platform_setup_done);
               set_code_buffer:
                  next_resp = plain(code_buffer_set_done);
               set_image_buffer:
                  next_resp = plain(image_buffer_set_done);
               processing_setup_command:
                  next_resp = plain(setup_done);
               statistics_setup_command,
               statistics_read_command:
                  next_resp = pack(statistics_report, engine_rpt);
               line_buffer_read_command:
                  next_resp = pack(line_buffer_report, engine_rpt);
               default:
               begin
                  next_resp = plain(version_report);
                  next_resp.image_addr = VERSION_WORD;
               end
            endcase
         end
         else if (cmd_code == 5'h06 || cmd_code == 5'h07)
         begin
            if (code_buffer_limit_state && have_op)
            begin
               launch      = 1'b1;
               launch_line = (cmd_code == 5'h07);
               next_limit  = 1'b0;
            end
            else if (continuous_mode && cmd_code == 5'h07)
            begin
               next_resp = pack(continuous_stop_done, engine_rpt);
               respond   = 1'b1;
               end_cont  = 1'b1;
            end
            else if (have_op && cmd_code == 5'h06)
               launch = 1'b1;
            else
            begin
               next_resp = plain(nothing_pending_done);
               respond   = 1'b1;
               end_cont  = 1'b1;
            end
         end
         else
         begin
            launch     = 1'b1;
            launch_cmd = cmd_t'(cmd_code);
         end
      end
      else if (engine_done && state == st_busy)
      begin
         respond = 1'b1;
         case (engine_rpt.outcome)
            end_cb_empty:
            begin
               next_resp  = pack(code_buffer_empty, engine_rpt);
               next_limit = 1'b1;
            end
            end_cb_full:
            begin
               next_resp  = pack(code_buffer_full, engine_rpt);
               next_limit = 1'b1;
            end
            end_err_lines:
               next_resp = pack(last_op == line_operation_command
                                ? line_decode_aborted
                                : block_decode_aborted,
                                engine_rpt);
            default:
            begin
               set_cont = 1'b1;
               case (last_op)
                  block_operation_command:
                     next_resp = pack(engine_rpt.decode ? block_decode_done
                                      : block_encode_done, engine_rpt);
                  line_operation_command:
                     next_resp = pack(engine_rpt.decode ? line_decode_done
                                      : line_encode_done, engine_rpt);
                  line_end_code:
                     next_resp = pack(engine_rpt.decode ? line_end_found
                                      : line_end_added, engine_rpt);
                  control_return_command:
                     next_resp = pack(engine_rpt.decode
                                      ? control_return_found
                                      : control_return_added, engine_rpt);
                  fill_command:
                     next_resp = pack(fill_done, engine_rpt);
                  read_line_tag:
                     next_resp = pack(tag_read_done, engine_rpt);
                  white_mask_command:
                     next_resp = pack(mask_done, engine_rpt);
                  default:
                     next_resp = pack(transfer_done, engine_rpt);
               endcase
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencing

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         state <= st_idle;
      else if (cmd_valid && state == st_busy)
         state <= st_idle;
      else if (launch)
         state <= st_busy;
      else if (engine_done)
         state <= st_idle;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         last_op <= block_operation_command;
         have_op <= 1'b0;
      end
      else if (launch)
      begin
         last_op <= launch_cmd;
         have_op <= 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         engine_start       <= 1'b0;
         engine_cmd         <= block_operation_command;
         engine_single_line <= 1'b0;
         engine_cancel      <= 1'b0;
      end
      else
      begin
         engine_start       <= launch;
         engine_cmd         <= launch_cmd;
         engine_single_line <= launch_line;
         engine_cancel      <= cmd_valid && state == st_busy;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         code_buffer_limit_state <= 1'b0;
      else
         code_buffer_limit_state <= next_limit;
   end

   // continuous mode runs from a completed operation until stopped
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         continuous_mode <= 1'b0;
      else if (end_cont)
         continuous_mode <= 1'b0;
      else if (set_cont)
         continuous_mode <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         resp_valid <= 1'b0;
         resp       <= plain(resp_none);
      end
      else
      begin
         resp_valid <= respond;
         if (respond)
            resp <= next_resp;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         interrupt       <= 1'b0;
         completion_flag <= 1'b0;
      end
      else if (respond)
      begin
         interrupt       <= 1'b1;
         completion_flag <= 1'b1;
      end
      else if (completion_clear)
      begin
         interrupt       <= 1'b0;
         completion_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks

   sequence s_limit_entry;
      engine_done && state == st_busy &&
      (engine_rpt.outcome == end_cb_empty ||
       engine_rpt.outcome == end_cb_full) && !cmd_valid;
   endsequence

   a_limit_entry: assert property (@(posedge clk) disable iff (!rst_b)
      s_limit_entry |=> code_buffer_limit_state && resp_valid)
      else $error("limit state not entered");

   a_limit_reject: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_valid && state == st_idle && code_buffer_limit_state &&
      known_cmd(cmd_code) && !limit_ok(cmd_code)
      |=> resp_valid && resp.code == limit_state_command_error)
      else $error("limit state error missing");

   a_unknown_cmd: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_valid && state == st_idle && !known_cmd(cmd_code)
      |=> resp_valid && resp.code == unknown_command_error)
      else $error("unknown command not flagged");

   a_dup_request: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_valid && state == st_busy
      |=> engine_cancel && resp.code == duplicate_request_error
          && state == st_idle)
      else $error("duplicate request not flagged");

   a_no_launch_limit: assert property (@(posedge clk) disable iff (!rst_b)
      code_buffer_limit_state && cmd_valid && !limit_ok(cmd_code)
      |=> !engine_start)
      else $error("refused command started engine");

   a_irq_follows: assert property (@(posedge clk) disable iff (!rst_b)
      resp_valid |-> interrupt && completion_flag)
      else $error("interrupt not raised with response");

   a_irq_holds: assert property (@(posedge clk) disable iff (!rst_b)
      interrupt && !completion_clear |=> interrupt)
      else $error("interrupt dropped without clear");

   a_setup_plain: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_valid && state == st_idle && !code_buffer_limit_state &&
      cmd_code == 5'h04
      |=> resp.code == setup_done && resp.code_addr == ADDR_ZERO)
      else $error("setup confirmation wrong");

   a_abort_line: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_valid && state == st_idle && code_buffer_limit_state &&
      have_op && cmd_code == 5'h07
      |=> engine_start && engine_single_line && !code_buffer_limit_state)
      else $error("abort did not resume single line");

   a_idle_ack: assert property (@(posedge clk) disable iff (!rst_b)
      cmd_valid && state == st_idle && !have_op && !continuous_mode &&
      !code_buffer_limit_state && (cmd_code == 5'h06 || cmd_code == 5'h07)
      |=> resp.code == nothing_pending_done ##1 !engine_start)
      else $error("set-okay missing");

endmodule // codec_response_generator

// File: verif/engine_model.sv
// behavioural processing engine facing the response generator
// assumes start and cancel are one-cycle pulses on the same clock
module engine_model
   import codec_resp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        engine_start,
   input  wire logic        engine_cancel,
   input  wire logic [7:0]  delay,
   input  wire engine_rpt_t cfg,
   output logic             engine_done,
   output engine_rpt_t      engine_rpt
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       busy;
   logic [7:0] left;

   ////////////////////////////////////////////////////////////////////////
   // cancel wins so a dropped run never reports late
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         busy        <= 1'b0;
         left        <= 8'h00;
         engine_done <= 1'b0;
      end
      else
      begin
         engine_done <= 1'b0;
         if (engine_cancel)
            busy <= 1'b0;
         else if (engine_start)
         begin
            busy <= 1'b1;
            left <= delay;
         end
         else if (busy && left == 8'h00)
         begin
            busy        <= 1'b0;
            engine_done <= 1'b1;
         end
         else if (busy)
            left <= left - 8'h01;
      end
   end

   // report is a level; also read as table contents
   assign engine_rpt = cfg;
endmodule // engine_model

// File: verif/tb_codec_response_generator.sv
// self-checking bench for the response generator
// assumes the engine model stands on the engine side
module tb_codec_response_generator;
   import codec_resp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed
   {
      cmd_t c; logic d; outcome_t o; resp_t e; logic [2:0] m;
   } op_t;

   logic               clk = 1'b0;
   logic               rst_b = 1'b0;
   logic               cmd_valid = 1'b0;
   logic [CMD_W-1:0]   cmd_code = 5'h00;
   logic               completion_clear = 1'b0;
   logic [7:0]         delay = 8'h03;
   engine_rpt_t        cfg = '{end_ok, 1'b0, 16'h0123, 24'h10a0b0,
                               24'h20c0d0, 4'h5};
   logic               engine_done, engine_start, engine_single_line;
   logic               engine_cancel, resp_valid, interrupt;
   logic               completion_flag, code_buffer_limit_state;
   logic               continuous_mode;
   cmd_t               engine_cmd;
   engine_rpt_t        engine_rpt;
   response_t          resp, r;
   int                 mismatches = 0;
   int                 samples_checked = 0;
   int                 st_cnt = 0;
   int                 cancel_cnt = 0;
   cmd_t               st_cmd;
   logic               st_single;

   always #12.5 clk = ~clk;

   codec_response_generator u_dut (.clk(clk), .rst_b(rst_b),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .engine_done(engine_done), .engine_rpt(engine_rpt),
      .completion_clear(completion_clear), .engine_start(engine_start),
      .engine_cmd(engine_cmd), .engine_single_line(engine_single_line),
      .engine_cancel(engine_cancel), .resp_valid(resp_valid),
      .resp(resp), .interrupt(interrupt),
      .completion_flag(completion_flag),
      .code_buffer_limit_state(code_buffer_limit_state),
      .continuous_mode(continuous_mode));

   engine_model u_eng (.clk(clk), .rst_b(rst_b),
      .engine_start(engine_start), .engine_cancel(engine_cancel),
      .delay(delay), .cfg(cfg), .engine_done(engine_done),
      .engine_rpt(engine_rpt));

   // start pulses last one cycle, so latch them here
   always @(posedge clk)
   begin
      if (engine_start === 1'b1)
      begin
         st_cnt++;
         st_cmd = engine_cmd;
         st_single = engine_single_line;
      end
      if (engine_cancel === 1'b1)
         cancel_cnt++;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk_code(input resp_t g, input resp_t e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR t=%0t code got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR t=%0t word got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk_flag(input logic g, input logic e);
      samples_checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR t=%0t flag got %h exp %h", $time, g, e);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic send(input logic [CMD_W-1:0] c);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code  <= c;
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask

   // bounded wait: a lost answer fails instead of hanging
   task automatic wait_resp();
      int n;
      n = 0;
      #1;
      while (resp_valid !== 1'b1 && n < 100)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_flag(resp_valid, 1'b1);
      r = resp;
   endtask

   task automatic issue(input logic [CMD_W-1:0] c, input resp_t e);
      send(c);
      wait_resp();
      chk_code(r.code, e);
   endtask

   task automatic clear();
      @(posedge clk);
      completion_clear <= 1'b1;
      @(posedge clk);
      completion_clear <= 1'b0;
      #1;
      chk_flag(interrupt, 1'b0);
   endtask

   task automatic set_eng(input outcome_t o, input logic d);
      @(posedge clk);
      cfg.outcome <= o;
      cfg.decode  <= d;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_idle();
      issue(continue_command, nothing_pending_done);
      issue(abort_command, nothing_pending_done);
      clear();
      $display("test idle done");
   endtask

   task automatic t_setup();
      cmd_t  c [4] = '{platform_setup_command, set_code_buffer,
                       set_image_buffer, processing_setup_command};
      resp_t e [4] = '{platform_setup_done, code_buffer_set_done,
                       image_buffer_set_done, setup_done};
      for (int i = 0; i < 4; i++)
      begin
         issue(c[i], e[i]);
         chk_flag(interrupt, 1'b1);
         chk_flag(completion_flag, 1'b1);
         clear();
      end
      foreach (c[i])
         issue(5'h13 + 5'(i * 4), unknown_command_error);
      issue(5'h00, unknown_command_error);
      issue(version_read_command, version_report);
      chk_word(r.image_addr, VERSION_WORD);
      $display("test setup done");
   endtask

   task automatic t_ops();
      op_t ops [14] = '{
         '{block_operation_command, 1'b0, end_ok, block_encode_done, 3'h7},
         '{block_operation_command, 1'b1, end_ok, block_decode_done, 3'h7},
         '{block_operation_command, 1'b1, end_err_lines,
           block_decode_aborted, 3'h7},
         '{line_operation_command, 1'b0, end_ok, line_encode_done, 3'h7},
         '{line_operation_command, 1'b1, end_ok, line_decode_done, 3'h7},
         '{line_operation_command, 1'b1, end_err_lines,
           line_decode_aborted, 3'h7},
         '{line_end_code, 1'b0, end_ok, line_end_added, 3'h4},
         '{line_end_code, 1'b1, end_found, line_end_found, 3'h4},
         '{control_return_command, 1'b0, end_ok, control_return_added, 3'h4},
         '{control_return_command, 1'b1, end_found,
           control_return_found, 3'h4},
         '{fill_command, 1'b0, end_ok, fill_done, 3'h4},
         '{read_line_tag, 1'b1, end_ok, tag_read_done, 3'h4},
         '{white_mask_command, 1'b0, end_ok, mask_done, 3'h2},
         '{transfer_operation_command, 1'b0, end_ok, transfer_done, 3'h2}};
      foreach (ops[i])
      begin
         set_eng(ops[i].o, ops[i].d);
         issue(ops[i].c, ops[i].e);
         chk_word(24'(st_cmd), 24'(ops[i].c));
         if (ops[i].m[0])
            chk_word(24'(r.lines), 24'h000123);
         if (ops[i].m[1])
            chk_word(r.image_addr, 24'h10a0b0);
         if (ops[i].m[2])
            chk_word({r.code_addr[19:0], r.code_bit}, 24'h0c0d05);
         clear();
      end
      $display("test ops done");
   endtask

   task automatic t_stop();
      set_eng(end_ok, 1'b0);
      issue(block_operation_command, block_encode_done);
      chk_flag(continuous_mode, 1'b1);
      issue(abort_command, continuous_stop_done);
      chk_word(r.code_addr, 24'h20c0d0);
      chk_flag(continuous_mode, 1'b0);
      issue(statistics_setup_command, statistics_report);
      chk_word(24'(r.lines), 24'h000123);
      issue(statistics_read_command, statistics_report);
      clear();
      $display("test stop done");
   endtask

   task automatic t_limit();
      int n;
      set_eng(end_cb_empty, 1'b1);
      issue(block_operation_command, code_buffer_empty);
      chk_flag(code_buffer_limit_state, 1'b1);
      n = st_cnt;
      issue(processing_setup_command, limit_state_command_error);
      issue(block_operation_command, limit_state_command_error);
      issue(set_code_buffer, code_buffer_set_done);
      chk_word(24'(st_cnt), 24'(n));
      issue(line_buffer_read_command, line_buffer_report);
      issue(statistics_read_command, statistics_report);
      set_eng(end_ok, 1'b1);
      issue(abort_command, block_decode_done);
      chk_flag(st_single, 1'b1);
      chk_word(24'(st_cmd), 24'(block_operation_command));
      clear();
      set_eng(end_cb_full, 1'b0);
      issue(block_operation_command, code_buffer_full);
      chk_flag(code_buffer_limit_state, 1'b1);
      set_eng(end_ok, 1'b0);
      issue(continue_command, block_encode_done);
      chk_flag(st_single, 1'b0);
      chk_flag(code_buffer_limit_state, 1'b0);
      clear();
      $display("test limit done");
   endtask

   task automatic t_dup();
      int n;
      n = cancel_cnt;
      delay <= 8'h14;
      send(line_operation_command);
      send(set_image_buffer);
      wait_resp();
      chk_code(r.code, duplicate_request_error);
      // cancel pulse is counted one edge after the answer
      @(posedge clk);
      #1;
      chk_word(24'(cancel_cnt - n), 24'h000001);
      delay <= 8'h03;
      clear();
      $display("test duplicate done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_idle();
      t_setup();
      t_ops();
      t_stop();
      t_limit();
      t_dup();
      print_verdict();
   end

   // the whole run needs well under two thousand cycles
   initial
   begin
      #(25 * 8000);
      mismatches++;
      print_verdict();
   end
endmodule // tb_codec_response_generator
